//--- design/ata_pio_pkg.sv
package ata_pio_pkg;

   // ========
   // Status and error bit positions
   localparam int STAT_BSY  = 7;
   localparam int STAT_DRDY = 6;
   localparam int STAT_DSC  = 4;
   localparam int STAT_DRQ  = 3;
   localparam int STAT_ERR  = 0;
   localparam int ERR_ABRT  = 2;
   localparam int ERR_IDNF  = 4;
   localparam int ERR_UNC   = 6;

   // ========
   // Values after reset, and the largest multiple block size
   localparam logic [7:0] ERR_RESET_VAL   = 8'h01;
   localparam logic [7:0] MULTI_RESET_VAL = 8'h10;
   localparam logic [7:0] MULTI_MAX       = 8'h10;

   // ========
   // Command codes
   localparam logic [7:0] CMD_READ_SECTORS  = 8'h20;
   localparam logic [7:0] CMD_WRITE_SECTORS = 8'h30;
   localparam logic [7:0] CMD_READ_MULTI    = 8'hC4;
   localparam logic [7:0] CMD_WRITE_MULTI   = 8'hC5;
   localparam logic [7:0] CMD_SET_MULTI     = 8'hC6;

   // ========
   // Sizes and timing
   localparam int    SECTOR_WORDS   = 256;
   localparam int    RCACHE_SECTORS = 64;
   localparam int    FIFO_WIDTH     = 16;
   localparam int    FIFO_DEPTH     = 8;
   localparam int    CLK_PERIOD_NS  = 20;
   localparam int    INIT_TIME_NS   = 10000;
   localparam int    INIT_CYCLES    = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam longint REALLOC_TIME_S = 20;
   localparam longint REALLOC_CYCLES = REALLOC_TIME_S * 64'd1000000000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      S_INIT,
      S_IDLE,
      S_RD_PREP,
      S_RD_XFER,
      S_WR_PREP,
      S_WR_XFER,
      S_WR_PROC
   } state_t;

endpackage

//--- design/ata_pio_cache_protocol.sv
// Overview of operation
// RULE_01 - Read cache hit served without media access.
// RULE_02 - Read miss fetches media into buffer first.
// RULE_03 - Read-ahead runs until cache full or command.
// RULE_04 - Cached write completes once data fully buffered.
// RULE_05 - Sequential writes never wait for media drain.
// RULE_06 - Activity indicator on while cached data unwritten.
// RULE_07 - Resets never discard buffered write data; power reset (sys_rst_i) still empties the write buffer.
// RULE_08 - Late write error reported later, ready cleared.
// RULE_09 - Addresses checked only at media access.
// RULE_10 - Reallocation keeps indicator on, bounded twenty seconds.
// RULE_11 - Host waits busy low, ready high first.
// RULE_12 - Status read, reset, command clear interrupt.
// RULE_13 - Host never writes command while busy/request.
// RULE_14 - Data-in: busy, then request plus interrupt.
// RULE_15 - Host writes parameters, command, reads status.
// RULE_16 - Multiple commands move blocks, others sectors.
// RULE_17 - Invalid parameter aborts with error and interrupt.
// RULE_18 - Media error: request, error, address, interrupt.
// RULE_19 - Defective sector data still delivered to host.
// RULE_20 - Host finishes the sector or block on error.
// RULE_21 - Data-out: busy, request per unit, busy again.
// RULE_22 - Data-out unit processed: request plus interrupt.
// RULE_23 - After reset busy during init, no interrupt.
// RULE_24 - Customary status and error bit layout.
`timescale 1ns/1ps
`default_nettype none

// ========
// Write buffer between host data port and media
module ata_wr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output var  logic             in_ready_o,
   output var  logic             out_valid_o,
   output var  logic [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        ready;
      logic                        valid;
   } fifo_st_t;

   fifo_st_t q;
   fifo_st_t n;
   logic     push;
   logic     pop;

   always_comb begin
      n = q;
      push = in_valid_i & q.ready;
      pop = out_ready_i & q.valid;
      if (push) begin
         n.mem[q.wp] = in_data_i;
         n.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
      end
      if (pop) begin
         n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.ready = (n.cnt != (AW+1)'(DEPTH));
      n.valid = (n.cnt != '0);
      if (sys_rst_i) begin
         n = '0;
         n.ready = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= n;
   end

   assign in_ready_o  = q.ready;
   assign out_valid_o = q.valid;
   assign out_data_o  = q.mem[q.rp];
endmodule

// ========
// Command sequencer behind the task file
module ata_pio_cache_protocol #(
   parameter int          SECTOR_WORDS   = ata_pio_pkg::SECTOR_WORDS,
   parameter int          RCACHE_SECTORS = ata_pio_pkg::RCACHE_SECTORS,
   parameter int          FIFO_DEPTH     = ata_pio_pkg::FIFO_DEPTH,
   parameter int unsigned REALLOC_CYCLES = 32'(ata_pio_pkg::REALLOC_CYCLES)
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        hard_rst_n_i,
   input  wire logic        soft_rst_i,
   input  wire logic        rcache_en_i,
   input  wire logic        wcache_en_i,
   input  wire logic        cmd_wr_i,
   input  wire logic [7:0]  cmd_code_i,
   input  wire logic [7:0]  sec_cnt_i,
   input  wire logic [27:0] lba_i,
   input  wire logic        status_rd_i,
   input  wire logic        alt_status_rd_i,
   input  wire logic        data_rd_i,
   input  wire logic        data_wr_i,
   input  wire logic [15:0] data_wr_word_i,
   output var  logic        host_wready_o,
   output var  logic [7:0]  status_o,
   output var  logic [7:0]  error_o,
   output var  logic [27:0] tf_lba_o,
   output var  logic        intrq_o,
   output var  logic        dasp_o,
   output var  logic [27:0] buf_sector_o,
   output var  logic [15:0] buf_word_o,
   output var  logic        media_rd_req_o,
   output var  logic [27:0] media_rd_lba_o,
   input  wire logic        media_rd_done_i,
   input  wire logic        media_err_i,
   input  wire logic        media_err_wr_i,
   input  wire logic        media_unc_i,
   input  wire logic        media_idnf_i,
   input  wire logic [27:0] media_err_lba_i,
   output var  logic        media_wvalid_o,
   output var  logic [15:0] media_wdata_o,
   input  wire logic        media_wready_i,
   input  wire logic        media_wbusy_i,
   input  wire logic        media_realloc_i
);

   // ========
   // State
   typedef struct packed {
      logic [1:0]          hsync;
      logic [1:0]          ssync;
      ata_pio_pkg::state_t st;
      logic                bsy;
      logic                drdy;
      logic                drq;
      logic                err;
      logic                intrq;
      logic                first;
      logic                multi;
      logic [7:0]          err_reg;
      logic [7:0]          mult;
      logic [27:0]         lba;
      logic [27:0]         tf_lba;
      logic [27:0]         prep_lba;
      logic [8:0]          sec_left;
      logic [8:0]          unit_left;
      logic [8:0]          prep_left;
      logic [15:0]         word_cnt;
      logic [27:0]         cache_lba;
      logic [15:0]         cache_cnt;
      logic                pf_off;
      logic                rd_req;
      logic [27:0]         rd_lba;
      logic                defer;
      logic [7:0]          defer_code;
      logic [27:0]         defer_lba;
      logic [31:0]         realloc_cnt;
      logic [15:0]         init_cnt;
      logic                dasp;
   } st_t;

   st_t  q;
   st_t  n;
   logic fifo_push;
   logic fifo_ready;
   logic fifo_valid;
   logic hit;
   logic last_word;
   logic busy_cmd;
   logic [7:0] ecode;

   function automatic logic [8:0] unit_of(input logic multi, input logic [7:0] mult,
                                           input logic [8:0] left);
      logic [8:0] m;
      m = multi ? {1'b0, mult} : 9'h001;
      return (left < m) ? left : m;
   endfunction

   function automatic logic in_cache(input logic [27:0] a, input logic [27:0] base,
                                     input logic [15:0] cnt);
      logic [27:0] d;
      d = a - base;
      return (d < 28'(cnt));
   endfunction

   // Only power reset empties the write buffer.
   ata_wr_fifo #(
      .WIDTH (ata_pio_pkg::FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),     // [RULE_07]
      .in_valid_i  (fifo_push),
      .in_data_i   (data_wr_word_i),
      .in_ready_o  (fifo_ready),
      .out_valid_o (fifo_valid),
      .out_data_o  (media_wdata_o),
      .out_ready_i (media_wready_i)
   );

   assign host_wready_o  = fifo_ready;
   assign media_wvalid_o = fifo_valid;
   // Back-pressure: a full buffer holds the host off mid-unit.
   assign fifo_push = data_wr_i & (q.st == ata_pio_pkg::S_WR_XFER) & q.drq; // [RULE_04]

   // ========
   // Next state
   always_comb begin
      n = q;
      n.hsync = {q.hsync[0], ~hard_rst_n_i};
      n.ssync = {q.ssync[0], soft_rst_i};
      hit = rcache_en_i & in_cache(q.prep_lba, q.cache_lba, q.cache_cnt);
      last_word = (q.word_cnt == 16'(SECTOR_WORDS - 1));
      busy_cmd = (q.st != ata_pio_pkg::S_IDLE) && (q.st != ata_pio_pkg::S_INIT);
      ecode = 8'h00;
      ecode[ata_pio_pkg::ERR_UNC] = media_unc_i;
      ecode[ata_pio_pkg::ERR_IDNF] = media_idnf_i;

      n.dasp = fifo_valid | media_wbusy_i | media_realloc_i;  // [RULE_06] [RULE_10]
      n.realloc_cnt = media_realloc_i ? q.realloc_cnt + 32'h1 : 32'h0;
      if (q.realloc_cnt == REALLOC_CYCLES) begin
         // Overrunning the bound is treated as a write failure for the next command.
         n.defer = 1'b1; // [RULE_10]
         n.defer_code = 8'h00;
         n.defer_code[ata_pio_pkg::ERR_IDNF] = 1'b1;
         n.defer_lba = q.rd_lba;
         n.drdy = 1'b0;
      end

      if (status_rd_i) begin
         n.intrq = 1'b0; // [RULE_12] [RULE_22]
      end

      case (q.st)
         ata_pio_pkg::S_INIT: begin
            n.init_cnt = q.init_cnt + 16'h1;
            if (q.init_cnt == 16'(ata_pio_pkg::INIT_CYCLES - 1)) begin
               n.bsy = 1'b0;                                  // [RULE_23]
               n.drdy = ~q.defer;
               n.st = ata_pio_pkg::S_IDLE;
            end
         end
         ata_pio_pkg::S_IDLE: begin
            if (media_rd_done_i && q.rd_req) begin
               n.rd_req = 1'b0;
               n.cache_cnt = q.cache_cnt + 16'h1;
            end
            else if (!q.rd_req && rcache_en_i && !q.pf_off && q.cache_cnt != 16'h0 &&
                     q.cache_cnt < 16'(RCACHE_SECTORS)) begin
               n.rd_req = 1'b1;                               // [RULE_03]
               n.rd_lba = q.cache_lba + 28'(q.cache_cnt);
            end
         end
         ata_pio_pkg::S_RD_PREP: begin
            if (q.prep_left == 9'h0) begin
               n.st = ata_pio_pkg::S_RD_XFER;
               n.drq = 1'b1;                                  // [RULE_14]
               n.bsy = 1'b0;
               n.intrq = 1'b1;
            end
            else if (hit && !q.rd_req) begin
               n.prep_lba = q.prep_lba + 28'h1;               // [RULE_01]
               n.prep_left = q.prep_left - 9'h1;
            end
            else if (!q.rd_req) begin
               n.rd_req = 1'b1;                               // [RULE_02]
               n.rd_lba = q.prep_lba;
            end
            else if (media_rd_done_i) begin
               n.rd_req = 1'b0;
               if (q.prep_lba == q.cache_lba + 28'(q.cache_cnt) &&
                   q.cache_cnt < 16'(RCACHE_SECTORS)) begin
                  n.cache_cnt = q.cache_cnt + 16'h1;
               end
               else begin
                  n.cache_lba = q.prep_lba;
                  n.cache_cnt = 16'h1;
               end
               n.prep_lba = q.prep_lba + 28'h1;
               n.prep_left = q.prep_left - 9'h1;
            end
         end
         ata_pio_pkg::S_RD_XFER: begin
            if (data_rd_i) begin
               n.word_cnt = q.word_cnt + 16'h1;
               if (last_word) begin
                  n.word_cnt = 16'h0;
                  n.lba = q.lba + 28'h1;
                  n.sec_left = q.sec_left - 9'h1;
                  n.unit_left = q.unit_left - 9'h1;
                  if (q.unit_left == 9'h1) begin
                     n.drq = 1'b0;                            // [RULE_14]
                     if (q.err || q.sec_left == 9'h1) begin
                        n.st = ata_pio_pkg::S_IDLE;
                     end
                     else begin
                        n.bsy = 1'b1;
                        n.st = ata_pio_pkg::S_RD_PREP;
                        n.unit_left = unit_of(q.multi, q.mult, q.sec_left - 9'h1); // [RULE_16]
                        n.prep_left = n.unit_left;
                     end
                  end
               end
            end
         end
         ata_pio_pkg::S_WR_PREP: begin
            n.drq = 1'b1; // [RULE_21]
            n.bsy = 1'b0;
            n.st = ata_pio_pkg::S_WR_XFER;
         end
         ata_pio_pkg::S_WR_XFER: begin
            if (fifo_push && fifo_ready) begin
               n.word_cnt = q.word_cnt + 16'h1;
               if (last_word) begin
                  n.word_cnt = 16'h0;
                  n.lba = q.lba + 28'h1;
                  n.sec_left = q.sec_left - 9'h1;
                  n.unit_left = q.unit_left - 9'h1;
                  if (q.unit_left == 9'h1) begin
                     n.drq = 1'b0;                            // [RULE_21]
                     n.st = q.err ? ata_pio_pkg::S_IDLE : ata_pio_pkg::S_WR_PROC;
                     n.bsy = ~q.err;
                  end
               end
            end
         end
         ata_pio_pkg::S_WR_PROC: begin
            // Without write caching the unit counts as processed only once it is on the media.
            if (wcache_en_i || (!fifo_valid && !media_wbusy_i)) begin // [RULE_05]
               n.bsy = 1'b0;
               n.intrq = 1'b1;                                // [RULE_04] [RULE_22]
               if (q.sec_left == 9'h0) begin
                  n.st = ata_pio_pkg::S_IDLE;
               end
               else begin
                  n.drq = 1'b1;
                  n.st = ata_pio_pkg::S_WR_XFER;
                  n.unit_left = unit_of(q.multi, q.mult, q.sec_left); // [RULE_16]
               end
            end
         end
         default: begin
            n.st = ata_pio_pkg::S_IDLE;
         end
      endcase

      if (media_err_i) begin                                  // [RULE_09]
         if (busy_cmd && (media_err_wr_i == (q.st >= ata_pio_pkg::S_WR_PREP))) begin
            n.err = 1'b1; // [RULE_18]
            n.err_reg = ecode;
            n.tf_lba = media_err_lba_i;
            n.bsy = 1'b0;
            n.drq = 1'b1;
            n.intrq = 1'b1;
            n.rd_req = 1'b0;
            n.st = media_err_wr_i ? ata_pio_pkg::S_WR_XFER : ata_pio_pkg::S_RD_XFER; // [RULE_19]
            n.lba = (q.st == ata_pio_pkg::S_RD_PREP) ? q.prep_lba : q.lba;
            n.unit_left = 9'h1;
            n.word_cnt = (q.st == ata_pio_pkg::S_RD_XFER || q.st == ata_pio_pkg::S_WR_XFER) ?
                         q.word_cnt : 16'h0;
         end
         else if (media_err_wr_i) begin
            n.defer = 1'b1; // [RULE_08]
            n.defer_code = ecode;
            n.defer_lba = media_err_lba_i;
            n.drdy = 1'b0;
         end
         else begin
            n.pf_off = 1'b1;
            n.rd_req = 1'b0;
         end
      end

      if (cmd_wr_i) begin
         n.intrq = 1'b0;                                      // [RULE_12]
         n.rd_req = 1'b0; // [RULE_03]
         n.pf_off = 1'b0;
         n.err = 1'b0;
         n.err_reg = 8'h00;
         n.word_cnt = 16'h0;
         n.first = 1'b1;
         n.lba = lba_i;
         n.prep_lba = lba_i;
         n.tf_lba = lba_i;
         n.sec_left = (sec_cnt_i == 8'h00) ? 9'h100 : {1'b0, sec_cnt_i};
         n.multi = (cmd_code_i == ata_pio_pkg::CMD_READ_MULTI) ||
                   (cmd_code_i == ata_pio_pkg::CMD_WRITE_MULTI);
         n.unit_left = unit_of(n.multi, q.mult, n.sec_left); // [RULE_16]
         n.prep_left = n.unit_left;
         if (q.defer) begin
            n.defer = 1'b0; // [RULE_08]
            n.drdy = 1'b1;
            n.err = 1'b1;
            n.err_reg = q.defer_code;
            n.tf_lba = q.defer_lba;
            n.bsy = 1'b0;
            n.drq = 1'b0;
            n.intrq = 1'b1;
            n.st = ata_pio_pkg::S_IDLE;
         end
         else if (cmd_code_i == ata_pio_pkg::CMD_READ_SECTORS ||
                  cmd_code_i == ata_pio_pkg::CMD_READ_MULTI) begin
            n.bsy = 1'b1; // [RULE_14]
            n.drq = 1'b0;
            n.st = ata_pio_pkg::S_RD_PREP;
         end
         else if (cmd_code_i == ata_pio_pkg::CMD_WRITE_SECTORS ||
                  cmd_code_i == ata_pio_pkg::CMD_WRITE_MULTI) begin
            n.bsy = 1'b1; // [RULE_21]
            n.drq = 1'b0;
            n.cache_cnt = 16'h0;
            n.st = ata_pio_pkg::S_WR_PREP;
         end
         else if (cmd_code_i == ata_pio_pkg::CMD_SET_MULTI && sec_cnt_i != 8'h00 &&
                  sec_cnt_i <= ata_pio_pkg::MULTI_MAX && (sec_cnt_i & (sec_cnt_i - 8'h1)) == 8'h00) begin
            n.mult = sec_cnt_i;
            n.bsy = 1'b0;
            n.drq = 1'b0;
            n.intrq = 1'b1;
            n.st = ata_pio_pkg::S_IDLE;
         end
         else begin
            n.err = 1'b1; // [RULE_17]
            n.err_reg = 8'h00;
            n.err_reg[ata_pio_pkg::ERR_ABRT] = 1'b1;
            n.bsy = 1'b0;
            n.drq = 1'b0;
            n.intrq = 1'b1;
            n.st = ata_pio_pkg::S_IDLE;
         end
      end

      // Host resets abort the command but leave cache contents and pending errors alone.
      if (q.hsync[1] || q.ssync[1]) begin
         n.st = ata_pio_pkg::S_INIT;                          // [RULE_23] [RULE_07]
         n.bsy = 1'b1;
         n.drq = 1'b0;
         n.err = 1'b0;
         n.intrq = 1'b0;                                      // [RULE_12]
         n.rd_req = 1'b0;
         n.init_cnt = 16'h0;
         n.err_reg = ata_pio_pkg::ERR_RESET_VAL;
         n.tf_lba = 28'h1;
         if (q.hsync[1]) begin
            n.mult = ata_pio_pkg::MULTI_RESET_VAL;
         end
      end

      if (sys_rst_i) begin
         n = '0;
         n.st = ata_pio_pkg::S_INIT;
         n.bsy = 1'b1;
         n.err_reg = ata_pio_pkg::ERR_RESET_VAL;
         n.mult = ata_pio_pkg::MULTI_RESET_VAL;
         n.tf_lba = 28'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= n;
   end

   // ========
   // Outputs
   always_comb begin
      status_o = 8'h00;
      status_o[ata_pio_pkg::STAT_BSY] = q.bsy;                // [RULE_24]
      status_o[ata_pio_pkg::STAT_DRDY] = q.drdy;
      status_o[ata_pio_pkg::STAT_DSC] = 1'b1;
      status_o[ata_pio_pkg::STAT_DRQ] = q.drq;
      status_o[ata_pio_pkg::STAT_ERR] = q.err;
   end

   assign error_o        = q.err_reg;
   assign tf_lba_o       = q.tf_lba;
   assign intrq_o        = q.intrq;
   assign dasp_o         = q.dasp;
   assign buf_sector_o   = q.lba;
   assign buf_word_o     = q.word_cnt;
   assign media_rd_req_o = q.rd_req;
   assign media_rd_lba_o = q.rd_lba;

endmodule

`default_nettype wire

//--- bench/media_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Media back end
module media_model (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        fail_i,
   input  wire logic        stall_i,
   input  wire logic        req_i,
   input  wire logic [27:0] lba_i,
   input  wire logic        wvalid_i,
   output var  logic        done_o,
   output var  logic        err_o,
   output var  logic        wbusy_o,
   output wire logic        unc_o,
   output wire logic [27:0] err_lba_o,
   output wire logic        wready_o,
   output wire logic        realloc_o
);
   logic [2:0] cnt;
   // Odd sectors answer slowly, so both paces reach the sequencer.
   wire logic go = req_i && cnt == (lba_i[0] ? 3'h6 : 3'h1);
   always_ff @(posedge clk_i) begin
      cnt     <= (sys_rst_i || !req_i || done_o || err_o) ? 3'h0 : cnt + 3'h1;
      done_o  <= !sys_rst_i && go && !done_o && !err_o && !fail_i;
      err_o   <= !sys_rst_i && go && !done_o && !err_o && fail_i;
      wbusy_o <= wvalid_i && wready_o;
   end
   assign unc_o     = err_o;
   assign err_lba_o = lba_i;
   assign wready_o  = !stall_i;
   assign realloc_o = stall_i;
endmodule
`default_nettype wire

//--- bench/ata_pio_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Protocol checker
module ata_pio_chk (
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   input wire logic       soft_rst_i,
   input wire logic       cmd_wr_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic       status_rd_i,
   input wire logic       alt_status_rd_i,
   input wire logic [7:0] status_o,
   input wire logic [7:0] error_o,
   input wire logic       intrq_o,
   input wire logic       dasp_o,
   input wire logic       media_wvalid_o,
   input wire logic       media_realloc_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic bad = !(cmd_code_i inside {8'h20, 8'h30, 8'hC4, 8'hC5, 8'hC6});
   a_init_busy: assert property ($fell(sys_rst_i) |-> status_o[7] [*8]) else $error("init busy");
   a_init_quiet: assert property ($fell(sys_rst_i) |-> !intrq_o [*8]) else $error("init irq");
   a_rd_clears: assert property (status_rd_i |=> !intrq_o) else $error("irq kept");
   a_alt_keeps: assert property (alt_status_rd_i && intrq_o && !status_rd_i && !cmd_wr_i && !soft_rst_i
      |=> intrq_o) else $error("irq lost");
   a_irq_ready: assert property ($rose(intrq_o) |-> !status_o[7]) else $error("irq busy");
   a_drq_idle: assert property (status_o[3] |-> !status_o[7]) else $error("drq busy");
   a_abort_code: assert property (cmd_wr_i && bad && status_o[6] && !status_o[7] && !soft_rst_i
      |-> ##[1:3] (status_o[0] && error_o[2] && intrq_o && !status_o[7])) else $error("no abort");
   a_fifo_led: assert property (media_wvalid_o |=> dasp_o) else $error("led off");
   a_realloc_led: assert property (media_realloc_i |=> dasp_o) else $error("led off");
   c_write: cover property (cmd_wr_i && cmd_code_i == 8'h30);
   c_multi: cover property (cmd_wr_i && cmd_code_i == 8'hC4);
   c_unc: cover property ($rose(error_o[6]));
endmodule
bind ata_pio_cache_protocol ata_pio_chk chk_u (.*);
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Host side stimulus and checking
module testbench;
   typedef struct packed {logic [7:0] sm, sv, em, ev;} note_t;
   note_t q[$];
   note_t e;
   logic clk_i = 0, sys_rst_i = 1, hard_rst_n_i = 1, soft_rst_i = 0, rcache_en_i = 1, wcache_en_i = 1;
   logic cmd_wr_i = 0, status_rd_i = 0, alt_status_rd_i = 0, data_rd_i = 0, data_wr_i = 0;
   logic fail = 0, stall = 0, irq_q = 0, media_err_wr_i = 0, media_idnf_i = 0, host_wready_o, intrq_o;
   logic dasp_o, media_rd_req_o, media_rd_done_i, media_err_i, media_unc_i, media_wvalid_o;
   logic media_wready_i, media_wbusy_i, media_realloc_i;
   logic [7:0] cmd_code_i = 0, sec_cnt_i = 0, status_o, error_o;
   logic [15:0] data_wr_word_i = 0, buf_word_o, media_wdata_o;
   logic [27:0] lba_i = 0, tf_lba_o, buf_sector_o, media_rd_lba_o, media_err_lba_i;
   int err_total = 0, comparisons = 0, seed = 32'h430D;
   logic [7:0] codes [6] = '{8'h00, 8'hFF, 8'h40, 8'hC6, 8'hC6, 8'hC6};
   logic [7:0] cnts [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h03, 8'h11};
   ata_pio_cache_protocol #(.SECTOR_WORDS(4), .REALLOC_CYCLES(64)) dut_u (.*);
   media_model mdl_u (.clk_i, .sys_rst_i, .fail_i(fail), .stall_i(stall), .req_i(media_rd_req_o),
      .lba_i(media_rd_lba_o), .wvalid_i(media_wvalid_o), .done_o(media_rd_done_i), .err_o(media_err_i),
      .wbusy_o(media_wbusy_i), .unc_o(media_unc_i), .err_lba_o(media_err_lba_i),
      .wready_o(media_wready_i), .realloc_o(media_realloc_i));
   always #10 clk_i = ~clk_i;
   task automatic chk(input logic [27:0] g, x, input string m);
      comparisons++;
      if (g !== x) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic note(input logic [7:0] sm, sv, em, ev);
      q.push_back({sm, sv, em, ev});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic waitst(input logic [7:0] m, v);
      int t;
      for (t = 0; t < 3000 && (status_o & m) !== v; t++) tick(1);
      chk(28'(t < 3000), 1, "stuck");
   endtask
   task automatic cmd(input logic [7:0] c, n, input logic [27:0] a);
      tick(1);
      waitst(8'h88, 8'h00);
      cmd_code_i = c;
      sec_cnt_i = n;
      lba_i = a;
      cmd_wr_i = 1;
      tick(1);
      cmd_wr_i = 0;
   endtask
   task automatic irq;
      int t;
      for (t = 0; t < 3000 && intrq_o !== 1'b1; t++) tick(1);
      alt_status_rd_i = 1;
      tick(1);
      alt_status_rd_i = 0;
      chk(intrq_o, 1, "alt read");
      status_rd_i = 1;
      tick(1);
      status_rd_i = 0;
   endtask
   task automatic rd(input int n);
      tick(1);
      data_rd_i = 1;
      tick(n);
      data_rd_i = 0;
   endtask
   task automatic wr(input int n);
      int k = 0;
      for (int t = 0; t < 400 && k < n; t++) begin
         tick(1);
         data_wr_i = host_wready_o && status_o[3];
         data_wr_word_i = 16'($random(seed));
         k += int'(data_wr_i);
      end
      tick(1);
      data_wr_i = 0;
   endtask
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(negedge clk_i) begin
      if (intrq_o === 1'b1 && irq_q !== 1'b1) begin
         e = q.size() ? q.pop_front() : '1;
         chk(28'(status_o & e.sm), 28'(e.sv), "status");
         chk(28'(error_o & e.em), 28'(e.ev), "error");
      end
      irq_q = intrq_o;
   end
   initial begin
      tick(40000);
      chk(0, 1, "timeout");
      tally_and_finish();
   end
   initial begin
      tick(12);
      sys_rst_i = 0;
      tick(600);
      chk(28'(status_o & 8'hC9), 28'h40, "init");
      chk(28'({error_o, intrq_o}), 28'h002, "init err");
      codes[2] = 8'h40 | 8'($random(seed) & 15);
      foreach (codes[i]) begin
         note(8'h89, 8'h01, 8'h04, 8'h04);
         cmd(codes[i], cnts[i], 0);
         irq();
      end
      fail = 1;
      note(8'h89, 8'h09, 8'h40, 8'h40);
      cmd(8'h20, 1, 300);
      irq();
      fail = 0;
      chk(tf_lba_o, 300, "bad lba");
      rd(3);
      chk(buf_word_o, 3, "word");
      chk(status_o[3], 1, "drq short");
      rd(1);
      chk(status_o[3], 0, "drq left");
      note(8'h89, 8'h08, 8'h00, 8'h00);
      cmd(8'h20, 1, 100);
      irq();
      chk(buf_sector_o, 100, "sector");
      rd(4);
      chk(status_o[3], 0, "drq end");
      tick(600);
      fail = 1;
      // A media failure here would show, so a clean answer proves the hit.
      note(8'h89, 8'h08, 8'h40, 8'h00);
      cmd(8'h20, 1, 101);
      irq();
      fail = 0;
      rd(4);
      note(8'h89, 8'h00, 8'h04, 8'h00);
      cmd(8'hC6, 2, 0);
      irq();
      note(8'h89, 8'h08, 8'h00, 8'h00);
      note(8'h89, 8'h08, 8'h00, 8'h00);
      cmd(8'hC4, 4, 200);
      irq();
      rd(4);
      chk(status_o[3], 1, "block");
      rd(4);
      irq();
      rd(8);
      stall = 1;
      note(8'h89, 8'h08, 8'h00, 8'h00);
      note(8'h89, 8'h08, 8'h00, 8'h00);
      note(8'h89, 8'h00, 8'h00, 8'h00);
      cmd(8'h30, 3, 500);
      waitst(8'h88, 8'h08);
      wr(4);
      irq();
      wr(4);
      chk({host_wready_o, dasp_o}, 1, "full");
      irq();
      stall = 0;
      wr(4);
      irq();
      tick(30);
      chk(dasp_o, 0, "drained");
      stall = 1;
      note(8'h89, 8'h00, 8'h00, 8'h00);
      cmd(8'h30, 1, 503);
      waitst(8'h88, 8'h08);
      wr(4);
      irq();
      soft_rst_i = 1;
      hard_rst_n_i = 0;
      tick(5);
      {soft_rst_i, hard_rst_n_i} = 2'b01;
      tick(600);
      chk({status_o[7:6], dasp_o}, 1, "kept");
      stall = 0;
      note(8'h81, 8'h01, 8'h10, 8'h10);
      cmd(8'h20, 1, 100);
      irq();
      chk(status_o[6], 1, "ready");
      chk(28'(q.size()), 0, "notes left");
      tally_and_finish();
   end
endmodule
`default_nettype wire
